// ### shared/pdl_regs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 10 MHz reference clock, 32-bit register words
// Notes: included by the display control logic and its bench
`ifndef PDL_REGS_SVH
`define PDL_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define PDL_OFS_CTRL 4'h0
`define PDL_OFS_DATA 4'h4
`define PDL_OFS_STAT 4'h8
`define PDL_ADDR_W 4

// ****************************************************************
// field positions and widths
// ****************************************************************
`define PDL_CTRL_W 14
`define PDL_COORD_W 10
`define PDL_X_LSB 0
`define PDL_Y_LSB 16
`define PDL_CTRL_RESET 14'h0000

// ****************************************************************
// bus answers
// ****************************************************************
`define PDL_RESP_OKAY 2'b00
`define PDL_RESP_SLVERR 2'b10

// ****************************************************************
// timing
// ****************************************************************
`define PDL_CLK_PERIOD_NS 100
`define PDL_CLR_TIME_NS 1000
`define PDL_SETTLE_TIME_NS 3000
`define PDL_STROBE_TIME_NS 2500
`define PDL_CTL_GAP_NS 1000
`define PDL_CLR_CYC (`PDL_CLR_TIME_NS / `PDL_CLK_PERIOD_NS)
`define PDL_SETTLE_CYC (`PDL_SETTLE_TIME_NS / `PDL_CLK_PERIOD_NS)
`define PDL_STROBE_CYC (`PDL_STROBE_TIME_NS / `PDL_CLK_PERIOD_NS)
`define PDL_CTL_GAP_CYC (`PDL_CTL_GAP_NS / `PDL_CLK_PERIOD_NS)
`define PDL_CNT_W 6

`endif

// ### shared/pdl_pkg.sv
// Purpose: types used by the display control logic; the bench does not import them
// Assumes: pdl_regs.svh holds every number
// Notes: ctrl_t bit order is the status word layout, msb first
`default_nettype none
package pdl_pkg;

	// ****************************************************************
	// control register, 14 bits; busy and light pen sit on top
	// ****************************************************************
	typedef struct packed {
		logic busy;
		logic lp;
		logic ready;
		logic x_only;
		logic y_only;
		logic [2:0] inten;
		logic [2:0] data_pia;
		logic [2:0] lp_pia;
	} ctrl_t;

	typedef enum {W_IDLE, W_GAP, W_RESP} wr_state_t;
	typedef enum {R_IDLE, R_STROBE, R_RESP} rd_state_t;

endpackage
`default_nettype wire

// ### logic/point_display_load_handshake.sv
// Purpose: host-to-point-display load handshake behind an AXI4-Lite slave
// Assumes: one 10 MHz clock; display pins are asynchronous
// Notes: host commands are register accesses, pulses are clock cycles
`include "pdl_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module point_display_load_handshake
	import pdl_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic [`PDL_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [`PDL_ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic DISPLAY_DONE_PULSE,
	input wire logic LIGHT_PEN_HIT,
	output logic BUFFER_CLEAR_PULSE,
	output logic DISPLAY_LOAD_PULSE,
	output logic [2:0] INTENSITY_PULSE,
	output logic [`PDL_COORD_W-1:0] X_BUFFER,
	output logic [`PDL_COORD_W-1:0] Y_BUFFER,
	output logic STATUS_DRIVE_ENABLE,
	output logic LIGHT_PEN_IRQ
);
	// ****************************************************************
	// bus write side
	// ****************************************************************
	wr_state_t wst_q, wst_d;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [`PDL_ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [1:0] bresp_q, bresp_d;
	logic [`PDL_CNT_W-1:0] wcnt_q, wcnt_d;
	logic ctrl_clear, ctrl_set, data_out_command;
	assign S_AXI_AWREADY = (wst_q == W_IDLE) && !aw_got_q;
	assign S_AXI_WREADY = (wst_q == W_IDLE) && !w_got_q;
	assign S_AXI_BVALID = (wst_q == W_RESP);
	assign S_AXI_BRESP = bresp_q;
	always_comb begin
		wst_d = wst_q;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		bresp_d = bresp_q;
		wcnt_d = wcnt_q;
		ctrl_clear = 1'b0;
		ctrl_set = 1'b0;
		data_out_command = 1'b0;
		case (wst_q)
			W_IDLE: begin
				if (S_AXI_AWVALID && S_AXI_AWREADY) begin
					aw_got_d = 1'b1;
					awaddr_d = S_AXI_AWADDR;
				end
				if (S_AXI_WVALID && S_AXI_WREADY) begin
					w_got_d = 1'b1;
					wdata_d = S_AXI_WDATA;
				end
				if (aw_got_q && w_got_q) begin
					aw_got_d = 1'b0;
					w_got_d = 1'b0;
					bresp_d = `PDL_RESP_OKAY;
					if (awaddr_q == `PDL_OFS_CTRL) begin
						ctrl_clear = 1'b1;
						wcnt_d = `PDL_CNT_W'(`PDL_CTL_GAP_CYC - 1);
						wst_d = W_GAP;
					end else if (awaddr_q == `PDL_OFS_DATA) begin
						data_out_command = 1'b1;
						wst_d = W_RESP;
					end else begin
						bresp_d = `PDL_RESP_SLVERR;
						wst_d = W_RESP;
					end
				end
			end
			W_GAP: begin
				if (wcnt_q == '0) begin
					ctrl_set = 1'b1;
					wst_d = W_RESP;
				end else begin
					wcnt_d = wcnt_q - 1'b1;
				end
			end
			W_RESP: begin
				if (S_AXI_BREADY) wst_d = W_IDLE;
			end
			default: wst_d = W_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			wst_q <= W_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			bresp_q <= `PDL_RESP_OKAY;
			wcnt_q <= '0;
		end else begin
			wst_q <= wst_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			bresp_q <= bresp_d;
			wcnt_q <= wcnt_d;
		end
	end

	// ****************************************************************
	// bus read side, status read strobe
	// ****************************************************************
	rd_state_t rst_q, rst_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [`PDL_CNT_W-1:0] rcnt_q, rcnt_d;
	logic light_pen_clear_pulse;
	ctrl_t ctl_q, ctl_d;
	logic [`PDL_COORD_W-1:0] x_q, x_d, y_q, y_d;
	assign S_AXI_ARREADY = (rst_q == R_IDLE);
	assign S_AXI_RVALID = (rst_q == R_RESP);
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;
	assign STATUS_DRIVE_ENABLE = (rst_q == R_STROBE);
	always_comb begin
		rst_d = rst_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		rcnt_d = rcnt_q;
		light_pen_clear_pulse = 1'b0;
		case (rst_q)
			R_IDLE: begin
				if (S_AXI_ARVALID) begin
					rresp_d = `PDL_RESP_OKAY;
					rdata_d = '0;
					if (S_AXI_ARADDR == `PDL_OFS_STAT) begin
						rcnt_d = `PDL_CNT_W'(`PDL_STROBE_CYC - 1);
						rst_d = R_STROBE;
					end else begin
						if (S_AXI_ARADDR == `PDL_OFS_CTRL) begin
							rdata_d[`PDL_CTRL_W-1:0] = ctl_q;
						end else if (S_AXI_ARADDR == `PDL_OFS_DATA) begin
							rdata_d[`PDL_X_LSB +: `PDL_COORD_W] = x_q;
							rdata_d[`PDL_Y_LSB +: `PDL_COORD_W] = y_q;
						end else begin
							rresp_d = `PDL_RESP_SLVERR;
						end
						rst_d = R_RESP;
					end
				end
			end
			R_STROBE: begin
				// flags reach the data lines one cycle into the strobe and stay to its end
				rdata_d = {{(32 - `PDL_CTRL_W){1'b0}}, ctl_q};
				if (rcnt_q == '0) begin
					light_pen_clear_pulse = 1'b1;
					rst_d = R_RESP;
				end else begin
					rcnt_d = rcnt_q - 1'b1;
				end
			end
			R_RESP: begin
				if (S_AXI_RREADY) rst_d = R_IDLE;
			end
			default: rst_d = R_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			rst_q <= R_IDLE;
			rdata_q <= '0;
			rresp_q <= `PDL_RESP_OKAY;
			rcnt_q <= '0;
		end else begin
			rst_q <= rst_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			rcnt_q <= rcnt_d;
		end
	end

	// ****************************************************************
	// display pin synchronisers
	// ****************************************************************
	logic done_s1_q, done_s2_q, done_s3_q, lp_s1_q, lp_s2_q;
	logic done_p;
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
			lp_s1_q <= 1'b0;
			lp_s2_q <= 1'b0;
		end else begin
			done_s1_q <= DISPLAY_DONE_PULSE;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
			lp_s1_q <= LIGHT_PEN_HIT;
			lp_s2_q <= lp_s1_q;
		end
	end
	assign done_p = done_s2_q && !done_s3_q;

	// ****************************************************************
	// display control: move, settling delay, clear window, load
	// ****************************************************************
	logic move_q, move_d, done_win_q, done_win_d;
	logic [`PDL_CNT_W-1:0] dly_q, dly_d, clr_q, clr_d;
	logic load_q, load_d, load;
	logic [2:0] inten_q, inten_d;
	ctrl_t set_val;
	always_comb begin
		set_val = ctrl_t'(wdata_q[`PDL_CTRL_W-1:0]);
		// early done skips load here; delay end picks it up
		load = (done_win_q && move_q && dly_q == '0)
			|| (dly_q == `PDL_CNT_W'(1) && !ctl_q.busy);
		ctl_d = ctl_q;
		if (ctrl_clear) ctl_d = `PDL_CTRL_RESET;
		if (ctrl_set) begin
			ctl_d = set_val;
			ctl_d.busy = ctl_q.busy;
			ctl_d.lp = ctl_q.lp;
		end
		if (data_out_command) ctl_d.ready = 1'b0;
		if (done_p) ctl_d.busy = 1'b0;
		if (load) begin
			ctl_d.busy = 1'b1;
			ctl_d.ready = 1'b1;
		end
		if (light_pen_clear_pulse) ctl_d.lp = 1'b0;
		if (lp_s2_q) ctl_d.lp = 1'b1;
		move_d = move_q;
		if (ctrl_clear || load) move_d = 1'b0;
		if (data_out_command) move_d = 1'b1;
		dly_d = (dly_q != '0) ? dly_q - 1'b1 : dly_q;
		if (data_out_command) begin
			dly_d = `PDL_CNT_W'(`PDL_SETTLE_CYC);
		end
		clr_d = (clr_q != '0) ? clr_q - 1'b1 : clr_q;
		done_win_d = done_win_q && (clr_q > `PDL_CNT_W'(1));
		if (done_p) begin
			clr_d = `PDL_CNT_W'(`PDL_CLR_CYC);
			done_win_d = 1'b1;
		end else if (data_out_command && !ctl_q.busy) begin
			clr_d = `PDL_CNT_W'(`PDL_CLR_CYC);
		end
		x_d = x_q;
		y_d = y_q;
		if (data_out_command) begin
			if (!ctl_q.y_only) begin
				x_d = wdata_q[`PDL_X_LSB +: `PDL_COORD_W];
			end
			if (!ctl_q.x_only) begin
				y_d = wdata_q[`PDL_Y_LSB +: `PDL_COORD_W];
			end
		end
		load_d = load;
		inten_d = load ? ctl_q.inten : 3'h0;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			ctl_q <= `PDL_CTRL_RESET;
			move_q <= 1'b0;
			dly_q <= '0;
			clr_q <= '0;
			done_win_q <= 1'b0;
			x_q <= '0;
			y_q <= '0;
			load_q <= 1'b0;
			inten_q <= 3'h0;
		end else begin
			ctl_q <= ctl_d;
			move_q <= move_d;
			dly_q <= dly_d;
			clr_q <= clr_d;
			done_win_q <= done_win_d;
			x_q <= x_d;
			y_q <= y_d;
			load_q <= load_d;
			inten_q <= inten_d;
		end
	end

	// ****************************************************************
	// display outputs
	// ****************************************************************
	assign BUFFER_CLEAR_PULSE = (clr_q != '0);
	assign DISPLAY_LOAD_PULSE = load_q;
	assign INTENSITY_PULSE = inten_q;
	assign X_BUFFER = x_q;
	assign Y_BUFFER = y_q;
	assign LIGHT_PEN_IRQ = ctl_q.lp;
endmodule
`default_nettype wire

// ### testbench/pdl_asserts.sv
// Purpose: port checks for the display load handshake
// Assumes: one clock, RST_B synchronous active low
// Notes: bound into every instance of the block
`timescale 1ns/10ps
`default_nettype none
module pdl_asserts (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_RVALID,
	input wire logic DISPLAY_DONE_PULSE,
	input wire logic LIGHT_PEN_HIT,
	input wire logic BUFFER_CLEAR_PULSE,
	input wire logic DISPLAY_LOAD_PULSE,
	input wire logic [2:0] INTENSITY_PULSE,
	input wire logic STATUS_DRIVE_ENABLE,
	input wire logic LIGHT_PEN_IRQ
);
	logic [5:0] clr_q;
	logic [5:0] sde_q;
	logic armed_q;
	// ****
	// high-time counters, load seen since last done
	// ****
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			clr_q <= 6'h0;
			sde_q <= 6'h0;
			armed_q <= 1'b0;
		end else begin
			clr_q <= BUFFER_CLEAR_PULSE ? clr_q + 6'h1 : 6'h0;
			sde_q <= STATUS_DRIVE_ENABLE ? sde_q + 6'h1 : 6'h0;
			armed_q <= DISPLAY_LOAD_PULSE | (armed_q & ~DISPLAY_DONE_PULSE);
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	AST_LOAD_ONE: assert property (
		DISPLAY_LOAD_PULSE |=> !DISPLAY_LOAD_PULSE)
		else $error("load pulse wider than one cycle");
	AST_INT_LOAD: assert property (
		INTENSITY_PULSE != 3'h0 |-> DISPLAY_LOAD_PULSE)
		else $error("intensity pulse without load");
	AST_LOAD_DONE: assert property (
		DISPLAY_LOAD_PULSE |-> !armed_q)
		else $error("second load before done");
	AST_DONE_CLEAR: assert property (
		$rose(DISPLAY_DONE_PULSE) |-> ##[1:5] BUFFER_CLEAR_PULSE)
		else $error("done gave no clear pulse");
	AST_CLEAR_LEN: assert property (
		$past(RST_B) && $fell(BUFFER_CLEAR_PULSE) |-> clr_q == 6'd10)
		else $error("clear pulse not ten cycles");
	AST_STROBE: assert property (
		$past(RST_B) && $fell(STATUS_DRIVE_ENABLE) |->
		S_AXI_RVALID && sde_q == 6'd25)
		else $error("status strobe length wrong");
	AST_LP_SET: assert property (
		LIGHT_PEN_HIT [*4] |-> ##[0:3] LIGHT_PEN_IRQ)
		else $error("light pen hit not flagged");
	AST_LP_HOLD: assert property (
		$past(RST_B) && $fell(LIGHT_PEN_IRQ) |-> ($past(STATUS_DRIVE_ENABLE)
		|| $past(STATUS_DRIVE_ENABLE, 2)) or (##[0:12] S_AXI_BVALID))
		else $error("light pen flag lost");
	cover property (DISPLAY_LOAD_PULSE);
	cover property ($fell(STATUS_DRIVE_ENABLE));
	cover property (LIGHT_PEN_IRQ ##1 !LIGHT_PEN_IRQ);
endmodule
bind point_display_load_handshake pdl_asserts u_pdl_asserts (.REF_CLK,
	.RST_B, .S_AXI_BVALID, .S_AXI_RVALID, .DISPLAY_DONE_PULSE,
	.LIGHT_PEN_HIT, .BUFFER_CLEAR_PULSE, .DISPLAY_LOAD_PULSE,
	.INTENSITY_PULSE, .STATUS_DRIVE_ENABLE, .LIGHT_PEN_IRQ);
`default_nettype wire

// ### testbench/pdl_display_model.sv
// Purpose: point display on the far side of the block
// Assumes: done rises dly-3 cycles after each load and falls dly cycles after it
// Notes: done held three cycles so the block's synchroniser sees it
`timescale 1ns/10ps
`default_nettype none
module pdl_display_model (
	input wire logic clk,
	input wire logic load,
	input wire logic pen_aim,
	input wire logic [7:0] dly,
	output logic done,
	output logic hit
);
	logic [7:0] cnt = 8'h0;
	// done closes each point that a load started
	assign done = cnt != 8'h0 && cnt < 8'h4;
	// pen sees light only while the point is lit
	assign hit = pen_aim && cnt > dly - 8'h6 && cnt <= dly - 8'h2;
	always @(posedge clk) begin
		if (load) cnt <= dly;
		else if (cnt != 8'h0) cnt <= cnt - 8'h1;
	end
endmodule
`default_nettype wire

// ### testbench/point_display_load_handshake_tb_top.sv
// Purpose: self-checking bench for the display load handshake
// Assumes: 10 MHz clock; display model on the far side
// Notes: settle 30, clear 10, strobe 25 cycles as the block fixes them
`include "pdl_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module point_display_load_handshake_tb_top;
	logic clk, rst_b, awv, wv, bre, arv, rre, pen;
	logic [3:0] awa, ara;
	logic [31:0] wd, rdata, rdv, d, e;
	logic [1:0] bresp, rresp, rrv;
	logic awr, wrd, bv, arr, rv, bcp, ld_pulse, sde, irq, done, hit;
	logic [2:0] inten, int_q;
	logic [9:0] xb, yb, ex, ey;
	logic [7:0] dly;
	logic [31:0] modes [3] = '{32'h0540, 32'h02c0, 32'h01bf};
	int failures, compares, n;
	point_display_load_handshake u_point_display_load_handshake (
		.REF_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rre), .DISPLAY_DONE_PULSE(done), .LIGHT_PEN_HIT(hit),
		.BUFFER_CLEAR_PULSE(bcp), .DISPLAY_LOAD_PULSE(ld_pulse),
		.INTENSITY_PULSE(inten), .X_BUFFER(xb), .Y_BUFFER(yb),
		.STATUS_DRIVE_ENABLE(sde), .LIGHT_PEN_IRQ(irq));
	pdl_display_model u_pdl_display_model (.clk, .load(ld_pulse),
		.pen_aim(pen), .dly, .done, .hit);
	always @(posedge clk) if (ld_pulse) int_q <= inten;
	// ****
	// checks, bus tasks, closing
	// ****
	task automatic chk(input string s, input logic [31:0] x, y);
		compares++;
		if (y !== x) begin
			failures++;
			$display("BAD %s expected %h seen %h", s, x, y);
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v,
		input logic [1:0] r);
		@(posedge clk);
		awa <= a;
		wd <= v;
		{awv, wv, bre} <= 3'h7;
		fork
			begin
				do @(negedge clk); while (!awr);
				@(posedge clk);
				awv <= 1'b0;
			end
			begin
				do @(negedge clk); while (!wrd);
				@(posedge clk);
				wv <= 1'b0;
			end
		join
		do @(negedge clk); while (!bv);
		chk("bresp", r, bresp);
		@(posedge clk);
		bre <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		ara <= a;
		{arv, rre} <= 2'h3;
		do @(negedge clk); while (!arr);
		@(posedge clk);
		arv <= 1'b0;
		do @(negedge clk); while (!rv);
		rdv = rdata;
		rrv = rresp;
		@(posedge clk);
		rre <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] x);
		rd(a);
		chk("rdata", x, rdv);
	endtask
	task automatic wl;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!ld_pulse && n < 300);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#1000000;
		failures++;
		report_and_stop;
	end
	initial begin
		rst_b = 1'b0;
		{awv, wv, bre, arv, rre, pen} = 6'h0;
		{awa, ara, wd, ex, ey} = 60'h0;
		dly = 8'd60;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rc(`PDL_OFS_CTRL, 32'h0);
		rd(4'hc);
		chk("rresp", `PDL_RESP_SLVERR, rrv);
		wr(`PDL_OFS_STAT, 32'h0, `PDL_RESP_SLVERR);
		wr(`PDL_OFS_CTRL, 32'hffffffff, `PDL_RESP_OKAY);
		rc(`PDL_OFS_CTRL, 32'h0fff);
		wr(`PDL_OFS_CTRL, 32'h0, `PDL_RESP_OKAY);
		rc(`PDL_OFS_CTRL, 32'h0);
		for (int i = 0; i < 3; i++) begin
			pen = (i == 1);
			d = {6'h0, 10'h2aa - 10'(i), 6'h0, 10'h155 + 10'(i)};
			if (!modes[i][9]) ex = d[9:0];
			if (!modes[i][10]) ey = d[25:16];
			wr(`PDL_OFS_CTRL, modes[i], `PDL_RESP_OKAY);
			wr(`PDL_OFS_DATA, d, `PDL_RESP_OKAY);
			@(negedge clk);
			chk("clear", 32'h1, bcp);
			chk("xbuf", ex, xb);
			chk("ybuf", ey, yb);
			wl;
			chk("settle", 32'h1, n >= 27 && n <= 30);
			@(negedge clk);
			chk("inten", modes[i][8:6], int_q);
			repeat (70) @(negedge clk);
			e = modes[i] | 32'h0800 | (i == 1 ? 32'h1000 : 32'h0);
			rc(`PDL_OFS_CTRL, e);
			chk("irq", e[12], irq);
			rc(`PDL_OFS_STAT, e);
			chk("irq", 32'h0, irq);
		end
		dly = 8'd40;
		wr(`PDL_OFS_DATA, 32'h0, `PDL_RESP_OKAY);
		wl;
		repeat (22) @(negedge clk);
		wr(`PDL_OFS_DATA, 32'h00110022, `PDL_RESP_OKAY);
		@(negedge clk);
		chk("xbuf", 32'h022, xb);
		wl;
		chk("early", 32'h1, n >= 27 && n <= 30);
		dly = 8'd100;
		repeat (60) @(negedge clk);
		wr(`PDL_OFS_DATA, 32'h0, `PDL_RESP_OKAY);
		wl;
		repeat (5) @(negedge clk);
		wr(`PDL_OFS_DATA, 32'h00330044, `PDL_RESP_OKAY);
		wl;
		chk("doneload", 32'h1, n >= 85 && n <= 100);
		wl;
		chk("idle", 32'd300, n);
		rc(`PDL_OFS_CTRL, 32'h09bf);
		rc(`PDL_OFS_DATA, 32'h00330044);
		report_and_stop;
	end
endmodule
`default_nettype wire
